// File: src/zvp_defines.svh
// constants of the zoomed-video port control block
// assumes inclusion by bare name from the package and the design modules
`ifndef ZVP_DEFINES_SVH
`define ZVP_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ZVP_OFS_PRESENT_STATE   8'h08
`define ZVP_OFS_FORCE_EVENT     8'h0c
`define ZVP_OFS_SOCKET_CONTROL  8'h10
`define ZVP_OFS_CARD_CONTROL    8'h91
`define ZVP_OFS_DIAGNOSTIC      8'h93

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ZVP_BIT_SUPPORT         27
`define ZVP_BIT_FORCE_SUPPORT   27
`define ZVP_BIT_IN_USE          11
`define ZVP_BIT_STD_CAPABLE     10
`define ZVP_BIT_SOCKET_ENABLE   9
`define ZVP_BIT_LEGACY_ENABLE   6
`define ZVP_BIT_PORT_SEL        5
`define ZVP_BIT_STD_DISABLE     0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ZVP_RST_CARD_CONTROL    8'h00
`define ZVP_RST_DIAGNOSTIC      8'h00
`define ZVP_RST_SUPPORT         1'b0
`define ZVP_RST_SOCKET_ENABLE   1'b0

`endif

// File: src/zvp_pkg.sv
// types of the zoomed-video port control block
// assumes zvp_defines.svh is on the include path
`include "zvp_defines.svh"

package zvp_pkg;

    // whole state of the control block, two sockets
    typedef struct packed {
        logic [1:0][7:0] card_control;   // one per socket function
        logic [7:0]      diagnostic;
        logic [1:0]      support;        // platform_video_support per socket
        logic [1:0]      socket_enable;  // socket_video_enable per socket
        logic            sel0_n;
        logic            sel1_n;
        logic            active;
        logic [1:0]      addr_hi_oe;
        logic [1:0]      addr_lo_oe;
        logic [31:0]     rdata;
        logic            ack;
    } zvp_state_s;

endpackage : zvp_pkg

// File: src/zvp_select.sv
// priority selection of the zoomed-video source socket
// assumes effective enables computed by the parent; purely combinational
`timescale 1ns/100ps

module zvp_select (
    // effective enables and priority
    input  wire logic [1:0] enable_i,
    input  wire logic       port_sel_i,
    // steering to external bus drivers
    output logic            sel0_n_o,
    output logic            sel1_n_o,
    output logic            active_o
);

    // ------------------------------------------------------------------
    // truth table
    // ------------------------------------------------------------------
    logic pick0;
    logic pick1;

    // priority only matters with both enabled
    always_comb begin
        pick0 = 1'b0;
        pick1 = 1'b0;
        if (enable_i == 2'b11) begin
            pick0 = ~port_sel_i;
            pick1 = port_sel_i;
        end else begin
            pick0 = enable_i[0];
            pick1 = enable_i[1];
        end
    end

    // active-low selects, high when none chosen
    assign sel0_n_o = ~pick0;
    assign sel1_n_o = ~pick1;
    assign active_o = |enable_i;

endmodule // zvp_select

// File: src/zvp_ctrl.sv
// zoomed-video port control: registers, address line enables, source select
// assumes a single-cycle register access port, synchronous to ref_clk_i
//
// Overview of operation
// - A set legacy enable bit in a socket's card control register floats that socket's A25-A4.
// - While video is on, a socket keeps driving A3-A0 so configuration stays reachable.
// - Socket 0 select goes low only when socket 0 is chosen, socket 1 likewise, else both high.
// - With both sockets enabled the priority bit picks socket 0 at 0 and socket 1 at 1.
// - With no socket enabled both selects are high and the activity output is low.
// - The activity output is high while at least one socket has video enabled.
// - Bit 27 of the present state register shows the read-only platform support flag.
// - Writing bit 27 of the force event register sets that socket's support flag.
// - Bit 11 of socket control reads 1 while either socket has video enabled.
// - Bit 10 of socket control reads 1 while the standardized model is enabled.
// - Bit 9 of socket control is a writable per-socket video enable.
// - Bit 0 of the diagnostic register at 1 disables the standardized model.
// - The legacy enable bit keeps working alongside the socket control enable.
`timescale 1ns/100ps
`include "zvp_defines.svh"

module zvp_ctrl #(
    parameter int NUM_SOCKETS = 2
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // register access port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic        reg_space_i,   // 0: configuration, 1: socket registers
    input  wire logic        reg_sock_i,    // socket or function number
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    output logic             reg_ack_o,
    // card address line drive enables
    output logic      [1:0]  card_addr_hi_oe_o,
    output logic      [1:0]  card_addr_lo_oe_o,
    // external bus driver steering
    output logic             socket0_video_select_n_o,
    output logic             socket1_video_select_n_o,
    output logic             video_active_out_o
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    // select table and register layout are defined for two sockets only
    if (NUM_SOCKETS != 2) begin : g_bad_sockets
        $error("zvp_ctrl serves exactly two sockets");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    zvp_pkg::zvp_state_s state_reg;
    zvp_pkg::zvp_state_s state_next;

    logic [1:0]  legacy_video_enable;
    logic [1:0]  eff_enable;
    logic        std_model_disable;
    logic        std_model_capable;
    logic        video_in_use;
    logic        port_sel;
    logic        sel0_n;
    logic        sel1_n;
    logic        active;

    // ------------------------------------------------------------------
    // effective enables
    // ------------------------------------------------------------------
    assign std_model_disable = state_reg.diagnostic[`ZVP_BIT_STD_DISABLE];
    assign std_model_capable = ~std_model_disable;
    // socket 0 function owns the priority bit, shared by both sources
    assign port_sel = state_reg.card_control[0][`ZVP_BIT_PORT_SEL];

    // per-socket enable: legacy path always works, model path only when on
    for (genvar s = 0; s < 2; s++) begin : g_sock
        assign legacy_video_enable[s] = state_reg.card_control[s][`ZVP_BIT_LEGACY_ENABLE];
        assign eff_enable[s] = legacy_video_enable[s]
                             | (state_reg.socket_enable[s] & std_model_capable);
    end

    assign video_in_use = |eff_enable;

    zvp_select u_select (
        .enable_i   (eff_enable),
        .port_sel_i (port_sel),
        .sel0_n_o   (sel0_n),
        .sel1_n_o   (sel1_n),
        .active_o   (active)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // register writes, reads and registered pin levels
    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;

        // writes
        if (reg_wr_i) begin
            if (!reg_space_i) begin
                unique case (reg_addr_i)
                    `ZVP_OFS_CARD_CONTROL: begin
                        state_next.card_control[reg_sock_i] = reg_wdata_i[7:0];
                    end
                    `ZVP_OFS_DIAGNOSTIC: begin
                        state_next.diagnostic = reg_wdata_i[7:0];
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (reg_addr_i)
                    `ZVP_OFS_FORCE_EVENT: begin
                        // set only; writing 0 leaves the flag alone
                        if (reg_wdata_i[`ZVP_BIT_FORCE_SUPPORT]) begin
                            state_next.support[reg_sock_i] = 1'b1;
                        end
                    end
                    `ZVP_OFS_SOCKET_CONTROL: begin
                        state_next.socket_enable[reg_sock_i] =
                            reg_wdata_i[`ZVP_BIT_SOCKET_ENABLE];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // reads, answered one cycle later; unmapped offsets read zero
        if (reg_rd_i) begin
            state_next.ack   = 1'b1;
            state_next.rdata = 32'h0000_0000;
            if (!reg_space_i) begin
                unique case (reg_addr_i)
                    `ZVP_OFS_CARD_CONTROL: begin
                        state_next.rdata[7:0] = state_reg.card_control[reg_sock_i];
                    end
                    `ZVP_OFS_DIAGNOSTIC: begin
                        state_next.rdata[7:0] = state_reg.diagnostic;
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (reg_addr_i)
                    `ZVP_OFS_PRESENT_STATE: begin
                        state_next.rdata[`ZVP_BIT_SUPPORT] =
                            state_reg.support[reg_sock_i];
                    end
                    `ZVP_OFS_SOCKET_CONTROL: begin
                        state_next.rdata[`ZVP_BIT_IN_USE]        = video_in_use;
                        state_next.rdata[`ZVP_BIT_STD_CAPABLE]   = std_model_capable;
                        state_next.rdata[`ZVP_BIT_SOCKET_ENABLE] =
                            state_reg.socket_enable[reg_sock_i];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // pins follow the current enables with one cycle of latency
        state_next.sel0_n     = sel0_n;
        state_next.sel1_n     = sel1_n;
        state_next.active     = active;
        // legacy bit alone floats the upper lines
        state_next.addr_hi_oe = ~legacy_video_enable;
        // lower lines stay driven for card configuration access
        state_next.addr_lo_oe = 2'b11;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg.card_control  <= {`ZVP_RST_CARD_CONTROL, `ZVP_RST_CARD_CONTROL};
            state_reg.diagnostic    <= `ZVP_RST_DIAGNOSTIC;
            state_reg.support       <= {`ZVP_RST_SUPPORT, `ZVP_RST_SUPPORT};
            state_reg.socket_enable <= {`ZVP_RST_SOCKET_ENABLE, `ZVP_RST_SOCKET_ENABLE};
            state_reg.sel0_n        <= 1'b1;
            state_reg.sel1_n        <= 1'b1;
            state_reg.active        <= 1'b0;
            state_reg.addr_hi_oe    <= 2'b11;
            state_reg.addr_lo_oe    <= 2'b11;
            state_reg.rdata         <= 32'h0000_0000;
            state_reg.ack           <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o              = state_reg.rdata;
    assign reg_ack_o                = state_reg.ack;
    assign card_addr_hi_oe_o        = state_reg.addr_hi_oe;
    assign card_addr_lo_oe_o        = state_reg.addr_lo_oe;
    assign socket0_video_select_n_o = state_reg.sel0_n;
    assign socket1_video_select_n_o = state_reg.sel1_n;
    assign video_active_out_o       = state_reg.active;

endmodule // zvp_ctrl

// File: tb/zvp_ctrl_assertions.sv
// checker for the zoomed-video port control block
// assumes a bind onto zvp_ctrl; sees its ports only
`timescale 1ns/100ps
`include "zvp_defines.svh"

module zvp_ctrl_assertions #(
    parameter int NUM_SOCKETS = 2
) (
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rstn_i,
    // register port
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic        reg_space_i,
    input wire logic        reg_sock_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        reg_ack_o,
    // pins
    input wire logic [1:0]  card_addr_hi_oe_o,
    input wire logic [1:0]  card_addr_lo_oe_o,
    input wire logic        socket0_video_select_n_o,
    input wire logic        socket1_video_select_n_o,
    input wire logic        video_active_out_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------
    // access sequences
    // ------------------------------------------------------------
    sequence s_rd_ctrl;
        reg_rd_i && reg_space_i && reg_addr_i == `ZVP_OFS_SOCKET_CONTROL;
    endsequence
    sequence s_legacy0_on;
        reg_wr_i && !reg_space_i && !reg_sock_i && reg_wdata_i[`ZVP_BIT_LEGACY_ENABLE]
            && reg_addr_i == `ZVP_OFS_CARD_CONTROL;
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_lo_lines_on: assert property (card_addr_lo_oe_o == 2'h3)
        else $error("low address lines not driven");
    // the extra cycle after the write covers the pin register behind card control
    a_legacy_floats: assert property (s_legacy0_on ##1 !reg_wr_i |=>
        !card_addr_hi_oe_o[0]) else $error("upper lines still driven");
    a_sel_one_low: assert property (!(!socket0_video_select_n_o
        && !socket1_video_select_n_o)) else $error("both selects low");
    a_idle_quiet: assert property (socket0_video_select_n_o
        && socket1_video_select_n_o |-> !video_active_out_o) else $error("idle but active");
    a_active_any: assert property (!socket0_video_select_n_o
        || !socket1_video_select_n_o |-> video_active_out_o) else $error("active low");
    a_ctrl_bits: assert property (s_rd_ctrl |=> reg_rdata_o[31:12] == 20'h0
        && reg_rdata_o[11] == video_active_out_o) else $error("in-use bit wrong");
    a_rd_ack_next: assert property (reg_rd_i |=> reg_ack_o)
        else $error("read not answered");
    a_ack_from_rd: assert property (reg_ack_o |-> $past(reg_rd_i))
        else $error("ack without read");
    a_unmapped_zero: assert property (reg_rd_i && reg_space_i && reg_addr_i == 8'h14
        |=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
endmodule // zvp_ctrl_assertions

bind zvp_ctrl zvp_ctrl_assertions #(.NUM_SOCKETS(NUM_SOCKETS)) chk_u (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_space_i(reg_space_i), .reg_sock_i(reg_sock_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
    .card_addr_hi_oe_o(card_addr_hi_oe_o), .card_addr_lo_oe_o(card_addr_lo_oe_o),
    .socket0_video_select_n_o(socket0_video_select_n_o),
    .socket1_video_select_n_o(socket1_video_select_n_o),
    .video_active_out_o(video_active_out_o));

// File: tb/zvp_vid_mux.sv
// model of the three-state drivers in front of the graphics port
// assumes the three steering outputs of zvp_ctrl, one source each
`timescale 1ns/100ps

module zvp_vid_mux (
    // clock and steering
    input  wire logic       ref_clk_i,
    input  wire logic       sel0_n_i,
    input  wire logic       sel1_n_i,
    input  wire logic       active_i,
    // sources and shared port
    input  wire logic [7:0] src0_i,
    input  wire logic [7:0] src1_i,
    input  wire logic [7:0] src2_i,
    output logic      [7:0] pix_o
);
    logic [7:0] last_reg;

    // low enables; third source only while no socket owns the port
    always_comb begin
        if (!sel0_n_i) pix_o = src0_i;
        else if (!sel1_n_i) pix_o = src1_i;
        else if (!active_i) pix_o = src2_i;
        else pix_o = ~last_reg; // floating port has no keeper
    end

    // last level seen, so a float never looks like held data
    always_ff @(posedge ref_clk_i) last_reg <= pix_o;
endmodule // zvp_vid_mux

// File: tb/tb_top.sv
// self-checking bench for zvp_ctrl with the driver model
// assumes the checker is bound by its own file
`timescale 1ns/100ps

module tb_top;
    logic        ref_clk_i, rstn_i, reg_wr_i, reg_rd_i, reg_space_i, reg_sock_i;
    logic [7:0]  reg_addr_i, pix, cc0, cc1;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    logic        reg_ack_o, sel0_n, sel1_n, active, dis;
    logic [1:0]  hi_oe, lo_oe, en;
    logic [2:0]  ex;
    int          err_total, compares, cyc;
    // card ctrl 0, card ctrl 1, socket enables, model off, {sel0_n,sel1_n,active}
    logic [21:0] rows [11] = '{{8'h00, 8'h00, 2'h0, 1'h0, 3'h6},
        {8'h40, 8'h00, 2'h0, 1'h0, 3'h3}, {8'h00, 8'h40, 2'h0, 1'h0, 3'h5},
        {8'h40, 8'h60, 2'h0, 1'h0, 3'h3}, {8'h60, 8'h40, 2'h0, 1'h0, 3'h5},
        {8'h60, 8'h00, 2'h0, 1'h0, 3'h3}, {8'h00, 8'h00, 2'h3, 1'h0, 3'h3},
        {8'h20, 8'h00, 2'h3, 1'h0, 3'h5}, {8'h20, 8'h00, 2'h2, 1'h1, 3'h6},
        {8'h00, 8'h00, 2'h2, 1'h0, 3'h5}, {8'h40, 8'h00, 2'h3, 1'h1, 3'h3}};

    zvp_ctrl #(.NUM_SOCKETS(2)) dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_space_i(reg_space_i),
        .reg_sock_i(reg_sock_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .card_addr_hi_oe_o(hi_oe),
        .card_addr_lo_oe_o(lo_oe), .socket0_video_select_n_o(sel0_n),
        .socket1_video_select_n_o(sel1_n), .video_active_out_o(active));
    zvp_vid_mux pm_u (.ref_clk_i(ref_clk_i), .sel0_n_i(sel0_n), .sel1_n_i(sel1_n),
        .active_i(active), .src0_i(8'h5a), .src1_i(8'ha5), .src2_i(8'h3c), .pix_o(pix));

    // ------------------------------------------------------------
    // clock, watchdog, helpers
    // ------------------------------------------------------------
    initial begin
        ref_clk_i = 1'h0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // about 250 cycles expected; a hang ends the run as a failure
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // strobe one cycle, fields held until after the taking edge
    task automatic wr(input logic sp, sk, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        {reg_space_i, reg_sock_i, reg_addr_i, reg_wdata_i} <= {sp, sk, a, d};
        reg_wr_i <= 1'h1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(input logic sp, sk, input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        {reg_space_i, reg_sock_i, reg_addr_i} <= {sp, sk, a};
        reg_rd_i <= 1'h1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'h0;
        #1;
        chk({31'h0, reg_ack_o}, 32'h1);
        chk(reg_rdata_o, e);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn_i, reg_wr_i, reg_rd_i, reg_space_i, reg_sock_i, reg_addr_i} = 13'h0;
        reg_wdata_i = 32'h0;
        repeat (8) @(posedge ref_clk_i);
        rstn_i <= 1'h1;
        foreach (rows[i]) begin
            {cc0, cc1, en, dis, ex} = rows[i];
            wr(1'h0, 1'h0, 8'h91, {24'h0, cc0});
            wr(1'h0, 1'h1, 8'h91, {24'h0, cc1});
            wr(1'h1, 1'h0, 8'h10, {22'h0, en[0], 9'h0});
            wr(1'h1, 1'h1, 8'h10, {22'h0, en[1], 9'h0});
            wr(1'h0, 1'h0, 8'h93, {31'h0, dis});
            repeat (2) @(posedge ref_clk_i);
            #1;
            chk({29'h0, sel0_n, sel1_n, active}, {29'h0, ex});
            chk({30'h0, hi_oe}, {30'h0, ~cc1[6], ~cc0[6]});
            chk({30'h0, lo_oe}, 32'h3);
            chk({24'h0, pix}, {24'h0, !ex[2] ? 8'h5a : !ex[1] ? 8'ha5 : 8'h3c});
            rd(1'h1, 1'h0, 8'h10, {20'h0, ex[0], ~dis, en[0], 9'h0});
            rd(1'h1, 1'h1, 8'h10, {20'h0, ex[0], ~dis, en[1], 9'h0});
            $display("row %0d done", i);
        end
        // support flag: set by force, read-only where it shows
        rd(1'h1, 1'h0, 8'h08, 32'h0);
        wr(1'h1, 1'h0, 8'h0c, 32'h0800_0000);
        rd(1'h1, 1'h0, 8'h08, 32'h0800_0000);
        wr(1'h1, 1'h0, 8'h08, 32'h0);
        rd(1'h1, 1'h0, 8'h08, 32'h0800_0000);
        rd(1'h1, 1'h1, 8'h08, 32'h0);
        rd(1'h1, 1'h0, 8'h0c, 32'h0);
        rd(1'h1, 1'h0, 8'h14, 32'h0);
        $display("flag test done");
        // bring-up as card software runs it; model still off, socket 0 flagged
        wr(1'h0, 1'h0, 8'h91, 32'h0);
        wr(1'h1, 1'h0, 8'h10, 32'h0);
        wr(1'h1, 1'h1, 8'h10, 32'h0);
        rd(1'h0, 1'h1, 8'h93, 32'h1);
        rd(1'h1, 1'h1, 8'h10, 32'h0);
        // capability reads 0, so the legacy bit is the only way in
        wr(1'h0, 1'h1, 8'h91, 32'h40);
        rd(1'h0, 1'h1, 8'h91, 32'h40);
        rd(1'h1, 1'h1, 8'h10, 32'h800);
        chk({29'h0, sel0_n, sel1_n, active}, 32'h5);
        wr(1'h0, 1'h1, 8'h91, 32'h0);
        wr(1'h0, 1'h0, 8'h93, 32'h0);
        // capable, supported and idle: software sets the socket enable
        rd(1'h1, 1'h0, 8'h08, 32'h0800_0000);
        rd(1'h1, 1'h0, 8'h10, 32'h400);
        wr(1'h1, 1'h0, 8'h10, 32'h200);
        rd(1'h1, 1'h0, 8'h10, 32'he00);
        chk({29'h0, sel0_n, sel1_n, active}, 32'h3);
        // unsupported, then supported but busy: software leaves it off
        rd(1'h1, 1'h1, 8'h08, 32'h0);
        wr(1'h1, 1'h1, 8'h0c, 32'h0800_0000);
        rd(1'h1, 1'h1, 8'h08, 32'h0800_0000);
        rd(1'h1, 1'h1, 8'h10, 32'hc00);
        chk({29'h0, sel0_n, sel1_n, active}, 32'h3);
        $display("software procedure test done");
        // reset in mid-run clears pins and registers
        @(posedge ref_clk_i);
        rstn_i <= 1'h0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk({29'h0, sel0_n, sel1_n, active}, 32'h6);
        chk({30'h0, hi_oe}, 32'h3);
        @(posedge ref_clk_i);
        rstn_i <= 1'h1;
        rd(1'h1, 1'h0, 8'h08, 32'h0);
        rd(1'h0, 1'h0, 8'h91, 32'h0);
        rd(1'h1, 1'h0, 8'h10, 32'h400);
        $display("reset test done");
        give_verdict();
    end
endmodule // tb_top
